/* File: hw/ssw_consts.svh */
// Offsets, field positions, reset values and timing constants of the supply supervisor.
// Summary of operation
// - Reset output asserted from power-up onward.
// - Active-low reset low while supply low.
// - Active-high reset high while supply low.
// - Release delay starts after supply rises.
// - Release delay 200 ms, short variant 25 ms.
// - Supply drop reasserts reset, abandons delay.
// - Manual reset low forces both outputs active.
// - Active-high output always complements active-low.
// - Either kick edge restarts watchdog interval.
// - Missed kick gives one release-delay reset.
// - Watchdog timeout restarts a full interval.
// - Floating kick input makes internal kicks.
// - Standard variant latches reset on kicks during reset.
// - Improved variant ignores kicks during reset.
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

// Clock rate and counter width.
`define SSW_CLK_HZ          20000000
`define SSW_CNT_W           25

// Times in milliseconds as specified.
`define SSW_DELAY_LONG_MS   200
`define SSW_DELAY_SHORT_MS  25
`define SSW_TOUT_LONG_MS    1600
`define SSW_TOUT_SHORT_MS   200

// Register byte offsets.
`define SSW_REG_CTRL        8'h00
`define SSW_REG_STATUS      8'h04
`define SSW_REG_EVENT       8'h08

// Control fields and reset value.
`define SSW_CTRL_SHORT      0
`define SSW_CTRL_IMPROVED   1
`define SSW_CTRL_RST        2'h0

// Status fields.
`define SSW_STAT_ASSERTED   0
`define SSW_STAT_SUPPLY     1
`define SSW_STAT_MANUAL     2
`define SSW_STAT_FLOAT      3
`define SSW_STAT_STATE_LO   4

// Event fields, write one to clear.
`define SSW_EVT_WDFIRED     0
`define SSW_EVT_LATCHED     1

// Bus answers.
`define SSW_RESP_OKAY       2'h0
`define SSW_RESP_SLVERR     2'h2

`endif

/* File: hw/ssw_pkg.sv */
// Types shared by the supply supervisor modules.
package ssw_pkg;

  // Supervisor sequencing states.
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN,
    ST_WD_PULSE,
    ST_LATCHED
  } ssw_state_t;

  // Decoded register selection.
  typedef enum logic [1:0] {
    REG_CTRL,
    REG_STATUS,
    REG_EVENT,
    REG_NONE
  } ssw_reg_t;

endpackage : ssw_pkg

/* File: hw/ssw_sync.sv */
// Two-flop synchroniser bank for pin inputs.
module ssw_sync #(
  parameter int W = 4
) (
  // Clocking.
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // Each bit has its own pair; the first stage feeds only the second.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stage1[i] <= 1'b0;
        dout[i]   <= 1'b0;
      end else if (ce) begin
        stage1[i] <= din[i];
        dout[i]   <= stage1[i];
      end
    end
  end

endmodule : ssw_sync

/* File: hw/ssw_timer.sv */
// Loadable down counter with a terminal flag.
`include "ssw_consts.svh"
module ssw_timer (
  // Clocking.
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Control.
  input  wire logic                   load,
  input  wire logic [`SSW_CNT_W-1:0]  load_val,
  output logic                        done
);

  logic [`SSW_CNT_W-1:0] count;

  assign done = (count == '0);

  // Load wins over counting; the counter parks at zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= load_val;
      end else if (!done) begin
        count <= count - `SSW_CNT_W'(1);
      end
    end
  end

endmodule : ssw_timer

/* File: hw/ssw_top.sv */
// Supply supervisor with manual reset, watchdog and an AXI4-Lite control port.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "ssw_consts.svh"
module ssw_top #(
  parameter logic [`SSW_CNT_W-1:0] DELAY_LONG_CYC  = `SSW_CNT_W'(`SSW_DELAY_LONG_MS * (`SSW_CLK_HZ / 1000)),
  parameter logic [`SSW_CNT_W-1:0] DELAY_SHORT_CYC = `SSW_CNT_W'(`SSW_DELAY_SHORT_MS * (`SSW_CLK_HZ / 1000)),
  parameter logic [`SSW_CNT_W-1:0] TOUT_LONG_CYC   = `SSW_CNT_W'(`SSW_TOUT_LONG_MS * (`SSW_CLK_HZ / 1000)),
  parameter logic [`SSW_CNT_W-1:0] TOUT_SHORT_CYC  = `SSW_CNT_W'(`SSW_TOUT_SHORT_MS * (`SSW_CLK_HZ / 1000))
) (
  // Clock, reset and clock enable.
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  // Pin inputs from outside the clock domain.
  input  wire logic        SUPPLY_ABOVE_THRESHOLD,
  input  wire logic        MANUAL_RESET_REQUEST_N,
  input  wire logic        WATCHDOG_KICK_IN,
  input  wire logic        KICK_FLOATING,
  // Reset outputs.
  output logic             RESET_N,
  output logic             RESET,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address channel.
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // Address decode, shared by the write and the read path.
  function automatic ssw_pkg::ssw_reg_t ssw_decode(input logic [7:0] addr);
    case (addr)
      `SSW_REG_CTRL:   ssw_decode = ssw_pkg::REG_CTRL;
      `SSW_REG_STATUS: ssw_decode = ssw_pkg::REG_STATUS;
      `SSW_REG_EVENT:  ssw_decode = ssw_pkg::REG_EVENT;
      default:         ssw_decode = ssw_pkg::REG_NONE;
    endcase
  endfunction : ssw_decode

  // Synchronised pins.
  logic [3:0]            pins_raw;
  logic [3:0]            pins_sync;
  logic                  supply_ok;
  logic                  manual_n;
  logic                  kick_s;
  logic                  float_s;

  // Kick edge detection.
  logic                  kick_prev;
  logic [2:0]            kick_primed;
  logic                  kick_edge;
  logic                  wd_kick;

  // Sequencer.
  ssw_pkg::ssw_state_t   state;
  ssw_pkg::ssw_state_t   next_state;
  logic                  hold_cause;
  logic                  in_reset;
  logic                  next_asserted;
  logic                  delay_load;
  logic                  wd_load;
  logic                  delay_done;
  logic                  wd_done;
  logic [`SSW_CNT_W-1:0] delay_val;
  logic [`SSW_CNT_W-1:0] tout_val;

  // Software visible state.
  logic [1:0]            ctrl;
  logic                  ctrl_short;
  logic                  ctrl_improved;
  logic                  latched;
  logic                  next_latched;
  logic                  latch_set;
  logic                  latch_clr;
  logic                  wd_fired;
  logic                  wd_fire_set;
  logic                  wd_fire_clr;

  // Bus slave.
  logic                  aw_hold;
  logic [7:0]            aw_addr;
  logic                  w_hold;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  aw_fire;
  logic                  w_fire;
  logic                  ar_fire;
  logic                  wr_go;
  logic                  next_aw_hold;
  logic                  next_w_hold;
  logic                  next_bvalid;
  logic                  next_rvalid;
  ssw_pkg::ssw_reg_t     wr_sel;
  ssw_pkg::ssw_reg_t     rd_sel;
  logic                  wr_low_byte;
  logic [31:0]           rd_word;
  logic [1:0]            rd_resp;
  logic [1:0]            wr_resp;

  assign pins_raw = {KICK_FLOATING, WATCHDOG_KICK_IN, MANUAL_RESET_REQUEST_N, SUPPLY_ABOVE_THRESHOLD};

  ssw_sync #(
    .W    (4)
  ) u_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .ce   (CE),
    .din  (pins_raw),
    .dout (pins_sync)
  );

  // The comparator already applies hysteresis, so one level carries both thresholds.
  assign supply_ok = pins_sync[0];
  assign manual_n  = pins_sync[1];
  assign kick_s    = pins_sync[2];
  assign float_s   = pins_sync[3];

  // edge from samples
  // Edges count only once both sync stages and the previous-sample flop hold real
  // pin data, three clocks after reset, so a kick pin that idles high does not
  // look like an edge and latch reset by mistake.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      kick_prev   <= 1'b0;
      kick_primed <= 3'h0;
    end else if (CE) begin
      kick_prev   <= kick_s;
      kick_primed <= {kick_primed[1:0], 1'b1};
    end
  end

  assign kick_edge = kick_primed[2] & (kick_s ^ kick_prev);
  assign wd_kick   = kick_edge | float_s;

  // Variant selection from the control register.
  assign ctrl_short    = ctrl[`SSW_CTRL_SHORT];
  assign ctrl_improved = ctrl[`SSW_CTRL_IMPROVED];
  assign delay_val     = ctrl_short ? DELAY_SHORT_CYC : DELAY_LONG_CYC;
  assign tout_val      = ctrl_short ? TOUT_SHORT_CYC : TOUT_LONG_CYC;

  // Release delay and watchdog counters.
  ssw_timer u_delay (
    .clk      (CLK),
    .rst      (SYS_RST),
    .ce       (CE),
    .load     (delay_load),
    .load_val (delay_val),
    .done     (delay_done)
  );

  ssw_timer u_wdog (
    .clk      (CLK),
    .rst      (SYS_RST),
    .ce       (CE),
    .load     (wd_load),
    .load_val (tout_val),
    .done     (wd_done)
  );

  assign hold_cause = ~supply_ok | ~manual_n;
  assign in_reset   = (state != ssw_pkg::ST_RUN);

  // improved variant ignores kicks
  // Only real pin edges latch; self-kicks of a floating input never do.
  assign latch_set    = kick_edge & ~ctrl_improved & in_reset;
  assign next_latched = latch_set | (latched & ~latch_clr);

  // Sequencer; a held cause overrides every state.
  always_comb begin
    next_state = state;
    delay_load = 1'b0;
    wd_load    = 1'b0;
    if (hold_cause) begin
      next_state = ssw_pkg::ST_HOLD;
    end else begin
      case (state)
        ssw_pkg::ST_HOLD: begin
          if (next_latched) begin
            next_state = ssw_pkg::ST_LATCHED;
          end else begin
            next_state = ssw_pkg::ST_DELAY;
            delay_load = 1'b1;
          end
        end
        ssw_pkg::ST_DELAY: begin
          if (next_latched) begin
            next_state = ssw_pkg::ST_LATCHED;
          end else if (delay_done) begin
            next_state = ssw_pkg::ST_RUN;
            wd_load    = 1'b1;
          end
        end
        ssw_pkg::ST_RUN: begin
          if (wd_done) begin
            next_state = ssw_pkg::ST_WD_PULSE;
            delay_load = 1'b1;
            wd_load    = 1'b1;
          end else if (wd_kick) begin
            wd_load    = 1'b1;
          end
        end
        ssw_pkg::ST_WD_PULSE: begin
          if (next_latched) begin
            next_state = ssw_pkg::ST_LATCHED;
          end else if (delay_done) begin
            next_state = ssw_pkg::ST_RUN;
            wd_load    = 1'b1;
          end
        end
        ssw_pkg::ST_LATCHED: begin
          if (!next_latched) begin
            next_state = ssw_pkg::ST_DELAY;
            delay_load = 1'b1;
          end
        end
        default: begin
          next_state = ssw_pkg::ST_HOLD;
        end
      endcase
    end
  end

  assign next_asserted = (next_state != ssw_pkg::ST_RUN);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ssw_pkg::ST_HOLD;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // outputs always complementary
  // Both outputs come from flops fed by one term, so they can never overlap.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RESET_N <= 1'b0;
      RESET   <= 1'b1;
    end else if (CE) begin
      RESET_N <= ~next_asserted;
      RESET   <= next_asserted;
    end
  end

  // Sticky flags; a set in the same cycle as the clear wins.
  assign wd_fire_set = (state == ssw_pkg::ST_RUN) & (next_state == ssw_pkg::ST_WD_PULSE);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latched  <= 1'b0;
      wd_fired <= 1'b0;
    end else if (CE) begin
      latched  <= next_latched;
      wd_fired <= wd_fire_set | (wd_fired & ~wd_fire_clr);
    end
  end

  // Bus handshakes; address and data are captured independently in any order.
  assign aw_fire      = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_fire       = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_fire      = S_AXI_ARVALID & S_AXI_ARREADY;
  assign wr_go        = aw_hold & w_hold & ~S_AXI_BVALID;
  assign next_aw_hold = ~wr_go & (aw_hold | aw_fire);
  assign next_w_hold  = ~wr_go & (w_hold | w_fire);
  assign next_bvalid  = wr_go | (S_AXI_BVALID & ~S_AXI_BREADY);
  assign next_rvalid  = ar_fire | (S_AXI_RVALID & ~S_AXI_RREADY);

  // Write decode; only the low byte lane carries fields.
  assign wr_sel      = ssw_decode(aw_addr);
  assign wr_low_byte = wr_go & w_strb[0];
  assign latch_clr   = wr_low_byte & (wr_sel == ssw_pkg::REG_EVENT) & w_data[`SSW_EVT_LATCHED];
  assign wd_fire_clr = wr_low_byte & (wr_sel == ssw_pkg::REG_EVENT) & w_data[`SSW_EVT_WDFIRED];
  assign wr_resp     = (wr_sel == ssw_pkg::REG_NONE) ? `SSW_RESP_SLVERR : `SSW_RESP_OKAY;

  // Read decode; unmapped offsets read zero with an error answer.
  assign rd_sel = ssw_decode(S_AXI_ARADDR);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `SSW_RESP_OKAY;
    case (rd_sel)
      ssw_pkg::REG_CTRL: begin
        rd_word[1:0] = ctrl;
      end
      ssw_pkg::REG_STATUS: begin
        rd_word[`SSW_STAT_ASSERTED]                         = in_reset;
        rd_word[`SSW_STAT_SUPPLY]                           = supply_ok;
        rd_word[`SSW_STAT_MANUAL]                           = ~manual_n;
        rd_word[`SSW_STAT_FLOAT]                            = float_s;
        rd_word[`SSW_STAT_STATE_LO+2:`SSW_STAT_STATE_LO]    = state;
      end
      ssw_pkg::REG_EVENT: begin
        rd_word[`SSW_EVT_WDFIRED] = wd_fired;
        rd_word[`SSW_EVT_LATCHED] = latched;
      end
      default: begin
        rd_resp = `SSW_RESP_SLVERR;
      end
    endcase
  end

  // Write channel state and captured payloads.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (CE) begin
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      if (aw_fire) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_fire) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  // Ready flags are registered, so they drop the cycle after a capture.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
    end else if (CE) begin
      S_AXI_AWREADY <= ~next_aw_hold;
      S_AXI_WREADY  <= ~next_w_hold;
      S_AXI_ARREADY <= ~next_rvalid;
    end
  end

  // Write response and control register update.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `SSW_RESP_OKAY;
      ctrl         <= `SSW_CTRL_RST;
    end else if (CE) begin
      S_AXI_BVALID <= next_bvalid;
      if (wr_go) begin
        S_AXI_BRESP <= wr_resp;
      end
      if (wr_low_byte && wr_sel == ssw_pkg::REG_CTRL) begin
        ctrl <= w_data[1:0];
      end
    end
  end

  // Read response; data are sampled at the address handshake.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `SSW_RESP_OKAY;
    end else if (CE) begin
      S_AXI_RVALID <= next_rvalid;
      if (ar_fire) begin
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_resp;
      end
    end
  end

endmodule : ssw_top

/* File: verification/ssw_cpu_model.sv */
// Behavioural model of the supervised processor that toggles the kick pin.
module ssw_cpu_model (
  // Clocking.
  input  wire logic       clk,
  input  wire logic       rst,
  // Kick control.
  input  wire logic       en,
  input  wire logic [7:0] period,
  output logic            kick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;

  // periodic kick toggle
  // Either edge counts, so one level flip per period is the cheapest kick.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      kick <= 1'b0;
    end else if (en && cnt >= period - 8'h01) begin
      cnt  <= 8'h00;
      kick <= ~kick;
    end else if (en) begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : ssw_cpu_model

/* File: verification/ssw_chk_properties.sv */
// Concurrent checks on the reset outputs of the supply supervisor.
`include "ssw_consts.svh"
module ssw_chk #(
  parameter logic [`SSW_CNT_W-1:0] DELAY_SHORT_CYC = 10
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched pins.
  input wire logic SUPPLY_ABOVE_THRESHOLD,
  input wire logic MANUAL_RESET_REQUEST_N,
  input wire logic KICK_FLOATING,
  input wire logic RESET_N,
  input wire logic RESET
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ok_cnt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Cycles with every hold cause clear; it saturates so a long run never wraps.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ok_cnt <= 8'h00;
    else if (!(SUPPLY_ABOVE_THRESHOLD && MANUAL_RESET_REQUEST_N)) ok_cnt <= 8'h00;
    else if (ok_cnt != 8'hff) ok_cnt <= ok_cnt + 8'h01;
  end

  // Supply good, no manual request, kick floating and reset released.
  sequence s_quiet;
    SUPPLY_ABOVE_THRESHOLD && MANUAL_RESET_REQUEST_N && KICK_FLOATING && RESET_N;
  endsequence

  property p_pwr_up; $fell(SYS_RST) |-> !RESET_N ##1 !RESET_N ##1 !RESET_N; endproperty
  property p_compl; RESET == !RESET_N; endproperty
  property p_supply_low; !SUPPLY_ABOVE_THRESHOLD [*3] |=> !RESET_N && RESET; endproperty
  property p_manual_low; !MANUAL_RESET_REQUEST_N [*3] |=> !RESET_N && RESET; endproperty
  property p_supply_fall; $fell(SUPPLY_ABOVE_THRESHOLD) |-> ##[1:4] !RESET_N; endproperty
  property p_manual_fall; $fell(MANUAL_RESET_REQUEST_N) |-> ##[1:4] RESET; endproperty
  property p_release; $rose(RESET_N) |-> ok_cnt >= 8'(DELAY_SHORT_CYC); endproperty
  property p_float; s_quiet [*8] |=> RESET_N; endproperty

  a_pwr_up: assert property (p_pwr_up) else $error("reset not held after power-up");
  a_compl: assert property (p_compl) else $error("outputs not complementary");
  a_supply_low: assert property (p_supply_low) else $error("reset free while supply low");
  a_manual_low: assert property (p_manual_low) else $error("reset free during manual request");
  a_supply_fall: assert property (p_supply_fall) else $error("supply drop not reasserting reset");
  a_manual_fall: assert property (p_manual_fall) else $error("manual request not honoured");
  a_release: assert property (p_release) else $error("reset released before delay");
  a_float: assert property (p_float) else $error("watchdog fired with floating kick");
endmodule : ssw_chk

bind ssw_top ssw_chk #(.DELAY_SHORT_CYC(DELAY_SHORT_CYC)) u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .SUPPLY_ABOVE_THRESHOLD(SUPPLY_ABOVE_THRESHOLD),
  .MANUAL_RESET_REQUEST_N(MANUAL_RESET_REQUEST_N), .KICK_FLOATING(KICK_FLOATING),
  .RESET_N(RESET_N), .RESET(RESET));

/* File: verification/ssw_tb_top.sv */
// Self-checking bench for the supply supervisor.
`include "ssw_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run brief.
  localparam int DL = 20;
  localparam int DS = 10;
  localparam int TL = 100;
  localparam int TS = 50;
  logic clk = 1'b0, sys_rst = 1'b1, supply = 1'b0, man_n = 1'b1, kick_float = 1'b0, kick_en = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic kick, reset_n, reset, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0, check_count = 0, cyc = 0;

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  ssw_top #(.DELAY_LONG_CYC(`SSW_CNT_W'(DL)), .DELAY_SHORT_CYC(`SSW_CNT_W'(DS)),
    .TOUT_LONG_CYC(`SSW_CNT_W'(TL)), .TOUT_SHORT_CYC(`SSW_CNT_W'(TS))) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .SUPPLY_ABOVE_THRESHOLD(supply),
    .MANUAL_RESET_REQUEST_N(man_n), .WATCHDOG_KICK_IN(kick), .KICK_FLOATING(kick_float),
    .RESET_N(reset_n), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  ssw_cpu_model i_cpu (.clk(clk), .rst(sys_rst), .en(kick_en), .period(8'h05), .kick(kick));

  // Verdict and end of run.
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end

  // Compare and count.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      aw_d = aw_d || awready === 1'b1;
      w_d = w_d || wready === 1'b1;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(`SSW_RESP_OKAY));
  endtask : wr

  // One bus read, judged against the expected word and answer.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, exp);
    chk("rresp", 32'(rresp), 32'(resp));
  endtask : rd

  // Waits for the reset output to reach a level within a cycle window.
  task automatic lvl(input logic v, input int lo, input int hi);
    int n = 0;
    while (reset_n !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("reset edge timing", 32'(n >= lo && n <= hi), 32'h1);
  endtask : lvl

  // Reset must stay released for n cycles.
  task automatic hold_high(input int n);
    int lows = 0;
    repeat (n) begin
      @(posedge clk);
      if (reset_n !== 1'b1) lows++;
    end
    chk("reset stayed released", lows, 0);
  endtask : hold_high

  // A missed kick: timeout, then one delay of reset.
  task automatic wd_fire(input int t, input int d);
    lvl(1'b0, t, t + 8);
    lvl(1'b1, d, d + 8);
  endtask : wd_fire

  task automatic t_power_up;
    repeat (20) @(posedge clk);
    chk("reset_n at power-up", reset_n, 0);
    chk("reset at power-up", reset, 1);
    supply <= 1'b1;
    lvl(1'b1, DL, DL + 8);
    chk("reset after release", reset, 0);
  endtask : t_power_up

  task automatic t_wd_long;
    wd_fire(TL, DL);
    wd_fire(TL, DL);
    rd(`SSW_REG_EVENT, 32'h1, `SSW_RESP_OKAY);
    wr(`SSW_REG_EVENT, 32'h1);
    rd(`SSW_REG_EVENT, 32'h0, `SSW_RESP_OKAY);
  endtask : t_wd_long

  task automatic t_kicks;
    wr(`SSW_REG_CTRL, 32'h3);
    rd(`SSW_REG_CTRL, 32'h3, `SSW_RESP_OKAY);
    kick_en <= 1'b1;
    hold_high(300);
    kick_en <= 1'b0;
    lvl(1'b0, TS - 6, TS + 8);
    lvl(1'b1, DS, DS + 8);
  endtask : t_kicks

  task automatic t_float;
    kick_float <= 1'b1;
    hold_high(3 * TS);
    kick_float <= 1'b0;
  endtask : t_float

  // A drop in mid-delay must restart the whole delay.
  task automatic t_supply_drop;
    supply <= 1'b0;
    repeat (4) @(posedge clk);
    chk("reset_n on drop", reset_n, 0);
    chk("reset on drop", reset, 1);
    repeat (6) @(posedge clk);
    supply <= 1'b1;
    repeat (6) @(posedge clk);
    supply <= 1'b0;
    repeat (4) @(posedge clk);
    supply <= 1'b1;
    lvl(1'b1, DS, DS + 8);
  endtask : t_supply_drop

  task automatic t_manual;
    man_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("reset_n on manual", reset_n, 0);
    chk("reset on manual", reset, 1);
    // Status: reset asserted, supply good, manual request seen, holding state.
    rd(`SSW_REG_STATUS, 32'h7, `SSW_RESP_OKAY);
    repeat (6) @(posedge clk);
    man_n <= 1'b1;
    lvl(1'b1, DS, DS + 8);
  endtask : t_manual

  // Kicks during reset: ignored when improved, latching when standard.
  task automatic t_latch;
    wr(`SSW_REG_EVENT, 32'h3);
    kick_en <= 1'b1;
    supply <= 1'b0;
    repeat (10) @(posedge clk);
    supply <= 1'b1;
    lvl(1'b1, DS, DS + 8);
    wr(`SSW_REG_CTRL, 32'h1);
    supply <= 1'b0;
    repeat (10) @(posedge clk);
    supply <= 1'b1;
    repeat (4 * DS) @(posedge clk);
    chk("reset_n latched", reset_n, 0);
    rd(`SSW_REG_EVENT, 32'h2, `SSW_RESP_OKAY);
    kick_en <= 1'b0;
    // A late kick edge meeting the clear in one cycle would win and keep the latch.
    repeat (4) @(posedge clk);
    wr(`SSW_REG_EVENT, 32'h2);
    lvl(1'b1, DS - 4, DS + 8);
  endtask : t_latch

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`SSW_REG_CTRL, 32'h0, `SSW_RESP_OKAY);
    rd(8'h0c, 32'h0, `SSW_RESP_SLVERR);
    t_power_up;
    t_wd_long;
    t_kicks;
    t_float;
    t_supply_drop;
    t_manual;
    t_latch;
    finish_test;
  end
endmodule : tb_top
